// ==== hw/qsg_group.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsg_group (
  // clock and reset
  input  wire logic        mclk,
  input  wire logic        sys_rst,
  // power-up indication, self-test outcome
  input  wire logic        power_up,
  input  wire logic        self_test_fail,
  // live status inputs (asynchronous)
  input  wire logic        power_summary,
  input  wire logic        detector_cold,
  input  wire logic        freq_summary,
  input  wire logic        mod_summary,
  input  wire logic        cal_summary,
  input  wire logic        error_tester_subgroup,
  // register port
  input  wire logic [2:0]  reg_sel,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [15:0] reg_wdata,
  output logic      [15:0] reg_rdata,
  input  wire logic        clear_status_command,
  // summary to status byte bit 3
  output logic             summary
);
  typedef struct packed {
    logic [5:0]  sync1;
    logic [5:0]  sync2;
    logic        self_fail;
    logic [15:0] cond_prev;
    logic [15:0] rise_filter;
    logic [15:0] fall_filter;
    logic [15:0] event_latch;
    logic [15:0] event_mask;
    logic [15:0] rdata;
  } qsg_state_t;

  qsg_state_t st;
  qsg_state_t next_st;
  logic [15:0] cond;
  logic [15:0] edges;
  logic [5:0]  raw;

  assign raw = {error_tester_subgroup, cal_summary, mod_summary,
                freq_summary, detector_cold, power_summary};

  // =========================================================
  // condition assembly
  always_comb begin
    cond = 16'h0000;
    cond[qsg_pkg::BIT_POWER] = st.sync2[0];
    cond[qsg_pkg::BIT_COLD]  = st.sync2[1];
    cond[qsg_pkg::BIT_FREQ]  = st.sync2[2];
    cond[qsg_pkg::BIT_MOD]   = st.sync2[3];
    cond[qsg_pkg::BIT_CAL]   = st.sync2[4];
    cond[qsg_pkg::BIT_SELF]  = st.self_fail;
    cond[qsg_pkg::BIT_TESTER] = st.sync2[5];
  end

  // filtered transitions per bit
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi++) begin : g_edge
      assign edges[gi] = (cond[gi] & ~st.cond_prev[gi] & st.rise_filter[gi])
                       | (~cond[gi] & st.cond_prev[gi]
                          & st.fall_filter[gi]);
    end
  endgenerate

  // =========================================================
  // next state
  always_comb begin
    next_st = st;
    next_st.sync1 = raw;
    next_st.sync2 = st.sync1;
    // only power-up sets or releases it; clear-status ignored
    if (power_up) begin
      next_st.self_fail = self_test_fail;
    end
    next_st.cond_prev = cond;
    if (reg_wr) begin
      unique case (reg_sel)
        qsg_pkg::SEL_RISE: next_st.rise_filter =
          reg_wdata & qsg_pkg::USED_MASK;
        qsg_pkg::SEL_FALL: next_st.fall_filter =
          reg_wdata & qsg_pkg::USED_MASK;
        qsg_pkg::SEL_MASK: next_st.event_mask =
          reg_wdata & qsg_pkg::USED_MASK;
        default: ;
      endcase
    end
    // new edges win over the read or clear-status clear
    if ((reg_rd && reg_sel == qsg_pkg::SEL_EVENT) || clear_status_command) begin
      next_st.event_latch = edges;
    end else begin
      next_st.event_latch = st.event_latch | edges;
    end
    next_st.rdata = st.rdata;
    if (reg_rd) begin
      unique case (reg_sel)
        qsg_pkg::SEL_CONDITION: next_st.rdata = cond;
        qsg_pkg::SEL_RISE:      next_st.rdata = st.rise_filter;
        qsg_pkg::SEL_FALL:      next_st.rdata = st.fall_filter;
        qsg_pkg::SEL_EVENT:     next_st.rdata = st.event_latch;
        qsg_pkg::SEL_MASK:      next_st.rdata = st.event_mask;
        default:                next_st.rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      // synchronisers and edge history keep running, so a level already
      // high at release is not taken for a fresh rising edge
      st.sync1       <= next_st.sync1;
      st.sync2       <= next_st.sync2;
      st.cond_prev   <= next_st.cond_prev;
      st.rise_filter <= qsg_pkg::RESET_VALUE;
      st.fall_filter <= qsg_pkg::RESET_VALUE;
      st.event_latch <= qsg_pkg::RESET_VALUE;
      st.event_mask  <= qsg_pkg::RESET_VALUE;
      st.rdata       <= 16'h0000;
      st.self_fail   <= next_st.self_fail;  // survives reset
    end else begin
      st <= next_st;
    end
  end

  assign reg_rdata = st.rdata;
  assign summary = |(st.event_latch & st.event_mask);

  // =========================================================
  // checks
  property p_unused_zero;
    @(posedge mclk) disable iff (sys_rst)
      ((reg_rdata & ~qsg_pkg::USED_MASK) == 16'h0000);
  endproperty
  a_unused_zero: assert property (p_unused_zero)
    else $error("unused bit read as one");

  property p_summary;
    @(posedge mclk) disable iff (sys_rst)
      (|(edges & st.event_mask)) && !(reg_wr && reg_sel == qsg_pkg::SEL_MASK)
        |=> summary;
  endproperty
  a_summary: assert property (p_summary)
    else $error("summary mismatch");

  property p_power;
    @(posedge mclk) disable iff (sys_rst)
      $rose(power_summary) |-> ##2 cond[qsg_pkg::BIT_POWER];
  endproperty
  a_power: assert property (p_power)
    else $error("power bit late");

  property p_freq;
    @(posedge mclk) disable iff (sys_rst)
      $rose(freq_summary) |-> ##2 cond[qsg_pkg::BIT_FREQ];
  endproperty
  a_freq: assert property (p_freq)
    else $error("frequency bit late");

  property p_self_hold;
    @(posedge mclk) disable iff (sys_rst)
      (st.self_fail && !power_up) |=> st.self_fail;
  endproperty
  a_self_hold: assert property (p_self_hold)
    else $error("self-test bit cleared");

  sequence s_rise_seen;
    !cond[qsg_pkg::BIT_COLD] ##1 cond[qsg_pkg::BIT_COLD]
      && st.rise_filter[qsg_pkg::BIT_COLD];
  endsequence
  property p_rise_latch;
    @(posedge mclk) disable iff (sys_rst)
      s_rise_seen |=> st.event_latch[qsg_pkg::BIT_COLD];
  endproperty
  a_rise_latch: assert property (p_rise_latch)
    else $error("rise not latched");

  property p_sticky;
    @(posedge mclk) disable iff (sys_rst)
      (st.event_latch[qsg_pkg::BIT_MOD] && !reg_rd && !clear_status_command)
        |=> st.event_latch[qsg_pkg::BIT_MOD];
  endproperty
  a_sticky: assert property (p_sticky)
    else $error("event bit lost");

  property p_read_clear;
    @(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_sel == qsg_pkg::SEL_EVENT)
        |=> reg_rdata == $past(st.event_latch)
            && st.event_latch == $past(edges);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("event read-clear wrong");

  property p_mask_store;
    @(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_sel == qsg_pkg::SEL_MASK)
        |=> st.event_mask == ($past(reg_wdata) & qsg_pkg::USED_MASK);
  endproperty
  a_mask_store: assert property (p_mask_store)
    else $error("mask not stored");

  // =========================================================
  // synchroniser latency, two flops from pin to condition bit
  property p_power_fall;
    @(posedge mclk) disable iff (sys_rst)
      $fell(power_summary) |-> ##2 !cond[qsg_pkg::BIT_POWER];
  endproperty
  a_power_fall: assert property (p_power_fall)
    else $error("power bit slow to clear");

  property p_freq_fall;
    @(posedge mclk) disable iff (sys_rst)
      $fell(freq_summary) |-> ##2 !cond[qsg_pkg::BIT_FREQ];
  endproperty
  a_freq_fall: assert property (p_freq_fall)
    else $error("frequency bit slow to clear");

  property p_cold;
    @(posedge mclk) disable iff (sys_rst)
      $rose(detector_cold) |-> ##2 cond[qsg_pkg::BIT_COLD];
  endproperty
  a_cold: assert property (p_cold)
    else $error("cold bit late");

  property p_mod;
    @(posedge mclk) disable iff (sys_rst)
      $rose(mod_summary) |-> ##2 cond[qsg_pkg::BIT_MOD];
  endproperty
  a_mod: assert property (p_mod)
    else $error("modulation bit late");

  property p_cal;
    @(posedge mclk) disable iff (sys_rst)
      $rose(cal_summary) |-> ##2 cond[qsg_pkg::BIT_CAL];
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration bit late");

  property p_tester;
    @(posedge mclk) disable iff (sys_rst)
      $rose(error_tester_subgroup) |-> ##2 cond[qsg_pkg::BIT_TESTER];
  endproperty
  a_tester: assert property (p_tester)
    else $error("error tester bit late");

  // =========================================================
  // register access
  property p_self_capture;
    @(posedge mclk) disable iff (sys_rst)
      power_up |=> st.self_fail == $past(self_test_fail);
  endproperty
  a_self_capture: assert property (p_self_capture)
    else $error("self-test outcome not captured");

  property p_cond_ro;
    @(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_sel == qsg_pkg::SEL_CONDITION)
        |=> st.rise_filter == $past(st.rise_filter)
            && st.fall_filter == $past(st.fall_filter)
            && st.event_mask == $past(st.event_mask);
  endproperty
  a_cond_ro: assert property (p_cond_ro)
    else $error("condition write had an effect");

  property p_cond_read;
    @(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_sel == qsg_pkg::SEL_CONDITION)
        |=> reg_rdata == $past(cond);
  endproperty
  a_cond_read: assert property (p_cond_read)
    else $error("condition read wrong");

  property p_rise_store;
    @(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_sel == qsg_pkg::SEL_RISE)
        |=> st.rise_filter == ($past(reg_wdata) & qsg_pkg::USED_MASK);
  endproperty
  a_rise_store: assert property (p_rise_store)
    else $error("rise filter not stored");

  property p_fall_store;
    @(posedge mclk) disable iff (sys_rst)
      (reg_wr && reg_sel == qsg_pkg::SEL_FALL)
        |=> st.fall_filter == ($past(reg_wdata) & qsg_pkg::USED_MASK);
  endproperty
  a_fall_store: assert property (p_fall_store)
    else $error("fall filter not stored");

  property p_unused_regs;
    @(posedge mclk) disable iff (sys_rst)
      ((st.rise_filter | st.fall_filter | st.event_latch | st.event_mask)
        & ~qsg_pkg::USED_MASK) == 16'h0000;
  endproperty
  a_unused_regs: assert property (p_unused_regs)
    else $error("unused register bit set");

  property p_reset_clear;
    @(posedge mclk)
      sys_rst |=> (st.rise_filter | st.fall_filter
                   | st.event_latch | st.event_mask) == 16'h0000;
  endproperty
  a_reset_clear: assert property (p_reset_clear)
    else $error("register survived reset");

  // =========================================================
  // event latching
  sequence s_fall_seen;
    cond[qsg_pkg::BIT_MOD] ##1 !cond[qsg_pkg::BIT_MOD]
      && st.fall_filter[qsg_pkg::BIT_MOD];
  endsequence
  property p_fall_latch;
    @(posedge mclk) disable iff (sys_rst)
      s_fall_seen |=> st.event_latch[qsg_pkg::BIT_MOD];
  endproperty
  a_fall_latch: assert property (p_fall_latch)
    else $error("fall not latched");

  // a rise that the filter blocks must leave a clear event bit clear
  sequence s_rise_masked;
    !cond[qsg_pkg::BIT_COLD] ##1 cond[qsg_pkg::BIT_COLD]
      && !st.rise_filter[qsg_pkg::BIT_COLD]
      && !st.event_latch[qsg_pkg::BIT_COLD];
  endsequence
  property p_rise_masked;
    @(posedge mclk) disable iff (sys_rst)
      s_rise_masked |=> !st.event_latch[qsg_pkg::BIT_COLD];
  endproperty
  a_rise_masked: assert property (p_rise_masked)
    else $error("blocked rise latched");

  property p_read_keep;
    @(posedge mclk) disable iff (sys_rst)
      (reg_rd && reg_sel == qsg_pkg::SEL_EVENT && edges[qsg_pkg::BIT_POWER])
        |=> st.event_latch[qsg_pkg::BIT_POWER];
  endproperty
  a_read_keep: assert property (p_read_keep)
    else $error("edge lost in read-clear");

  // summary drops in the cycle after the clear, no extra lag
  property p_summary_clear;
    @(posedge mclk) disable iff (sys_rst)
      ((reg_rd && reg_sel == qsg_pkg::SEL_EVENT) || clear_status_command)
        && edges == 16'h0000 |=> !summary;
  endproperty
  a_summary_clear: assert property (p_summary_clear)
    else $error("summary stayed high after clear");
endmodule
`default_nettype wire

// ==== hw/qsg_pkg.sv ====
// Summary of operation
// - bits 0,1,2,6,10,11,13,14,15 always read zero in every register
// - condition bit 3 follows the power sub-group summary
// - condition bit 4 set while leveling detector or oven reports cold
// - condition bit 5 follows the frequency sub-group summary
// - condition bit 7 follows the modulation sub-group summary
// - condition bit 8 follows the calibration sub-group summary
// - condition bit 9 set on failed power-up self-test, cleared by power cycle
// - clear-status command never clears the self-test failure bit
// - condition bit 12 follows the bit-error tester sub-group summary
// - condition register tracks live inputs; writes have no effect
// - condition query returns sum of weights of set bits
// - rise sets event if rise filter bit set; fall if fall filter set
// - filters written as weight sums, stored and read back
// - event register latches filtered transitions as sticky bits
// - event read returns content then clears all bits except those with a new edge in the read cycle
// - summary for status byte bit 3 set if any event and enable match
// - enable query returns the value most recently written
// - power sub-group summary drives condition bit 3
// - frequency sub-group summary drives condition bit 5
package qsg_pkg;
  // =========================================================
  // register selects
  localparam logic [2:0] SEL_CONDITION = 3'h0;
  localparam logic [2:0] SEL_RISE      = 3'h1;
  localparam logic [2:0] SEL_FALL      = 3'h2;
  localparam logic [2:0] SEL_EVENT     = 3'h3;
  localparam logic [2:0] SEL_MASK      = 3'h4;
  // =========================================================
  // bit positions
  localparam int BIT_POWER  = 3;
  localparam int BIT_COLD   = 4;
  localparam int BIT_FREQ   = 5;
  localparam int BIT_MOD    = 7;
  localparam int BIT_CAL    = 8;
  localparam int BIT_SELF   = 9;
  localparam int BIT_TESTER = 12;
  localparam logic [15:0] USED_MASK   = 16'h13B8;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
endpackage

// ==== sim/qsg_group_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module qsg_group_tb;
  logic        mclk, sys_rst, power_up, self_test_fail;
  logic        reg_wr, reg_rd, clear_status_command, summary;
  logic [2:0]  reg_sel;
  logic [5:0]  st, old, ns;
  logic [15:0] reg_wdata, reg_rdata, d, v, w, rf, ff, m, c0, c1, ev;
  int          n_fail, check_count;

  qsg_group i_qsg_group (.mclk(mclk), .sys_rst(sys_rst),
    .power_up(power_up), .self_test_fail(self_test_fail),
    .power_summary(st[0]), .detector_cold(st[1]), .freq_summary(st[2]),
    .mod_summary(st[3]), .cal_summary(st[4]),
    .error_tester_subgroup(st[5]), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .clear_status_command(clear_status_command), .summary(summary));

  // =========================================================
  // helpers
  function automatic logic [15:0] cond_of(input logic [5:0] s, input logic f);
    cond_of = {3'h0, s[5], 2'h0, f, s[4], s[3], 1'b0, s[2:0], 3'h0};
  endfunction

  task automatic chk(input string nm, input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] s, input logic [15:0] x);
    @(posedge mclk) begin reg_sel <= s; reg_wdata <= x; reg_wr <= 1'b1; end
    @(posedge mclk) reg_wr <= 1'b0;
  endtask

  // data lands on the edge that samples reg_rd, one cycle after it is driven
  task automatic rd(input logic [2:0] s, output logic [15:0] x);
    @(posedge mclk) begin reg_sel <= s; reg_rd <= 1'b1; end
    @(posedge mclk) reg_rd <= 1'b0;
    #1 x = reg_rdata;
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // =========================================================
  // clock, watchdog
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  initial begin
    #1000000;
    n_fail++;
    close_out();
  end

  // =========================================================
  // main sequence
  initial begin
    sys_rst = 1'b1; power_up = 1'b1; self_test_fail = 1'b1; st = 6'h00;
    reg_wr = 1'b0; reg_rd = 1'b0; reg_sel = 3'h0; reg_wdata = 16'h0000;
    clear_status_command = 1'b0;
    void'($urandom(61));
    repeat (16) @(posedge mclk);
    sys_rst <= 1'b0; power_up <= 1'b0; self_test_fail <= 1'b0;
    for (int i = 0; i < 24; i++) begin
      rf = 16'($urandom); ff = 16'($urandom); m = 16'($urandom);
      ns = 6'($urandom);
      // corners: every bit rising, then every bit falling
      if (i == 0) begin rf = 16'hFFFF; ff = 16'h0000; ns = 6'h3F; end
      if (i == 1) begin rf = 16'h0000; ff = 16'hFFFF; ns = 6'h00; end
      wr(qsg_pkg::SEL_RISE, rf); wr(qsg_pkg::SEL_FALL, ff);
      wr(qsg_pkg::SEL_MASK, m); wr(qsg_pkg::SEL_CONDITION, ~m);
      rd(qsg_pkg::SEL_EVENT, d);
      old = st;
      @(posedge mclk) st <= ns;
      repeat (4) @(posedge mclk);
      #1 c0 = cond_of(old, 1'b1);
      c1 = cond_of(ns, 1'b1);
      ev = ((~c0 & c1 & rf) | (c0 & ~c1 & ff)) & 16'h13B8;
      chk("summary", {15'h0000, summary}, {15'h0000, |(ev & m)});
      rd(qsg_pkg::SEL_RISE, d); chk("rise", d, rf & 16'h13B8);
      rd(qsg_pkg::SEL_FALL, d); chk("fall", d, ff & 16'h13B8);
      rd(qsg_pkg::SEL_MASK, d); chk("mask", d, m & 16'h13B8);
      rd(qsg_pkg::SEL_CONDITION, d); chk("cond", d, c1);
      rd(qsg_pkg::SEL_EVENT, d); chk("event", d, ev);
      rd(qsg_pkg::SEL_EVENT, d); chk("event_clr", d, 16'h0000);
      rd(3'(5 + i % 3), d); chk("unmapped", d, 16'h0000);
    end
    // edge near a clearing read must not vanish
    wr(qsg_pkg::SEL_RISE, 16'hFFFF); wr(qsg_pkg::SEL_FALL, 16'hFFFF);
    for (int k = 0; k < 4; k++) begin
      rd(qsg_pkg::SEL_EVENT, d);
      @(posedge mclk) st[0] <= ~st[0];
      repeat (k) @(posedge mclk);
      rd(qsg_pkg::SEL_EVENT, d); rd(qsg_pkg::SEL_EVENT, v);
      rd(qsg_pkg::SEL_EVENT, w);
      chk("same_cycle", (d | v | w) & 16'h0008, 16'h0008);
    end
    @(posedge mclk) st[0] <= ~st[0];
    repeat (4) @(posedge mclk);
    clear_status_command <= 1'b1;
    @(posedge mclk) clear_status_command <= 1'b0;
    rd(qsg_pkg::SEL_EVENT, d); chk("cls_event", d, 16'h0000);
    rd(qsg_pkg::SEL_CONDITION, d);
    chk("cls_cond", d, cond_of(st, 1'b1));
    // mid-run reset: self-test bit must outlive it
    @(posedge mclk) sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge mclk);
    for (int s = 1; s < 5; s++) begin
      rd(3'(s), d); chk("after_reset", d, 16'h0000);
    end
    rd(qsg_pkg::SEL_CONDITION, d);
    chk("self_test", d, cond_of(st, 1'b1));
    // only a power-up with a passing self-test clears bit 9
    @(posedge mclk) begin power_up <= 1'b1; self_test_fail <= 1'b0; end
    @(posedge mclk) power_up <= 1'b0;
    rd(qsg_pkg::SEL_CONDITION, d);
    chk("self_clear", d, cond_of(st, 1'b0));
    close_out();
  end
endmodule
`default_nettype wire
